// ---- inc/igfd_pkg.sv ----
// Summary of operation
// - Select clear: general call goes to receive FIFO.
// - Select set: hardware executes call, stores status code.
// - Hardware general call always handled transparently.
// - Transmit flush resets FIFO, FSM; keeps configuration.
// - Transmit flush crosses domains, then self-clears.
// - Receive flush resets circuitry, then self-clears.
// - Transmit DMA enable runs interface; resets to zero.
// - DMA end-of-transfer clears transmit DMA enable.
// - Receive DMA enable runs interface; end-of-transfer clears.
package igfd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int IGFD_ADDR_W = 8;
    localparam int IGFD_DATA_W = 32;
    localparam logic [IGFD_ADDR_W-1:0] IGFD_CTRL_OFS = 8'h00;
    localparam logic [IGFD_ADDR_W-1:0] IGFD_STATUS_OFS = 8'h08;

    localparam int IGFD_GCSEL_BIT = 6;
    localparam int IGFD_TXFL_BIT = 7;
    localparam int IGFD_RXFL_BIT = 8;
    localparam int IGFD_TXDMA_BIT = 9;
    localparam int IGFD_RXDMA_BIT = 10;

    localparam int IGFD_CODE_W = 8;
    localparam int IGFD_DIRECT_BIT = 8;

    localparam logic IGFD_BIT_RST = 1'h0;
    localparam logic [IGFD_CODE_W-1:0] IGFD_CODE_RST = 8'h00;
    localparam logic [IGFD_DATA_W-1:0] IGFD_RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int IGFD_SYS_CLK_NS = 100;
    localparam int IGFD_I2C_CLK_NS = 400;
    localparam int IGFD_I2C_DIV = IGFD_I2C_CLK_NS / IGFD_SYS_CLK_NS;
    localparam int IGFD_FLUSH_TICKS = 2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic hw;
        logic [IGFD_CODE_W-1:0] code;
    } igfd_gcall_t;

    typedef struct packed {
        logic valid;
        logic [IGFD_CODE_W-1:0] data;
    } igfd_byte_t;

endpackage : igfd_pkg

// ---- hdl/igfd_tick_div.sv ----
module igfd_tick_div
#(
    parameter int DIV = igfd_pkg::IGFD_I2C_DIV
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_tick
);
    import igfd_pkg::*;

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= '0;
            o_tick <= IGFD_BIT_RST;
        end
        else
        begin
            o_tick <= (cnt == LAST);
            cnt <= (cnt == LAST) ? '0 : cnt + CW'(1);
        end
    end

endmodule : igfd_tick_div

// ---- hdl/igfd_flush_seq.sv ----
module igfd_flush_seq
#(
    parameter int TICKS = igfd_pkg::IGFD_FLUSH_TICKS
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic i_tick,
    output logic o_busy
);
    import igfd_pkg::*;

    typedef enum logic [1:0] {FL_IDLE, FL_SYNC, FL_ACK} igfd_fl_state_t;

    localparam int CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

    igfd_fl_state_t state;
    logic [CW-1:0] cnt;

    // A start while busy is ignored; the flush already in progress covers it.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= FL_IDLE;
        end
        else
        begin
            case (state)
                FL_IDLE: if (i_start) state <= FL_SYNC;
                FL_SYNC: if (i_tick && cnt == LAST) state <= FL_ACK;
                FL_ACK: state <= FL_IDLE;
                default: state <= FL_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= '0;
        end
        else if (state != FL_SYNC)
        begin
            cnt <= '0;
        end
        else if (i_tick)
        begin
            cnt <= cnt + CW'(1);
        end
    end

    assign o_busy = (state != FL_IDLE);

endmodule : igfd_flush_seq

// ---- hdl/igfd_ctrl.sv ----
module igfd_ctrl
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [igfd_pkg::IGFD_ADDR_W-1:0] i_addr,
    input wire logic [igfd_pkg::IGFD_DATA_W-1:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [igfd_pkg::IGFD_DATA_W-1:0] o_rdata,
    input wire igfd_pkg::igfd_gcall_t i_gcall,
    output igfd_pkg::igfd_byte_t o_rx_push,
    output igfd_pkg::igfd_byte_t o_gcall_exec,
    output logic o_tx_flush,
    output logic o_rx_flush,
    input wire logic i_tx_fifo_full,
    input wire logic i_rx_fifo_empty,
    input wire logic i_dma_tx_eot,
    input wire logic i_dma_rx_eot,
    output logic o_dma_tx_req,
    output logic o_dma_rx_req,
    output logic o_tx_dma_en,
    output logic o_rx_dma_en
);
    import igfd_pkg::*;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic ctrl_wr;
    logic status_wr;
    logic gc_sel;
    logic tx_dma_en;
    logic rx_dma_en;
    logic i2c_tick;
    logic [1:0] flush_start;
    logic [1:0] flush_busy;
    logic [IGFD_CODE_W-1:0] status_code;
    logic status_direct;
    logic direct_call;
    logic [IGFD_DATA_W-1:0] rd_ctrl;
    logic [IGFD_DATA_W-1:0] rd_status;

    assign ctrl_wr = i_we && (i_addr == IGFD_CTRL_OFS);
    assign status_wr = i_we && (i_addr == IGFD_STATUS_OFS);

    // ------------------------------------------------------------
    // Configuration bits
    // ------------------------------------------------------------
    // Flushes never touch these flops, so configuration survives them.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            gc_sel <= IGFD_BIT_RST;
        end
        else if (ctrl_wr)
        begin
            gc_sel <= i_wdata[IGFD_GCSEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // DMA enables
    // ------------------------------------------------------------
    // End of transfer wins over a write in the same cycle.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_dma_en <= IGFD_BIT_RST;
        end
        else if (i_dma_tx_eot)
        begin
            tx_dma_en <= IGFD_BIT_RST;
        end
        else if (ctrl_wr)
        begin
            tx_dma_en <= i_wdata[IGFD_TXDMA_BIT];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_dma_en <= IGFD_BIT_RST;
        end
        else if (i_dma_rx_eot)
        begin
            rx_dma_en <= IGFD_BIT_RST;
        end
        else if (ctrl_wr)
        begin
            rx_dma_en <= i_wdata[IGFD_RXDMA_BIT];
        end
    end

    assign o_tx_dma_en = tx_dma_en;
    assign o_rx_dma_en = rx_dma_en;
    // Requests pause during a flush because the FIFO is held in reset.
    assign o_dma_tx_req = tx_dma_en && !i_tx_fifo_full && !flush_busy[0];
    assign o_dma_rx_req = rx_dma_en && !i_rx_fifo_empty && !flush_busy[1];

    // ------------------------------------------------------------
    // Flush sequencing
    // ------------------------------------------------------------
    igfd_tick_div #(
        .DIV(IGFD_I2C_DIV)
    ) u_tick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .o_tick(i2c_tick)
    );

    assign flush_start[0] = ctrl_wr && i_wdata[IGFD_TXFL_BIT];
    assign flush_start[1] = ctrl_wr && i_wdata[IGFD_RXFL_BIT];

    // Each flush waits for two of the slower I2C-side ticks before it reports done.
    for (genvar g = 0; g < 2; g++)
    begin : g_flush
        igfd_flush_seq #(
            .TICKS(IGFD_FLUSH_TICKS)
        ) u_seq (
            .i_clk(i_clk),
            .i_rst_n(i_rst_n),
            .i_start(flush_start[g]),
            .i_tick(i2c_tick),
            .o_busy(flush_busy[g])
        );
    end

    assign o_tx_flush = flush_busy[0];
    assign o_rx_flush = flush_busy[1];

    // ------------------------------------------------------------
    // General call handling
    // ------------------------------------------------------------
    assign direct_call = i_gcall.valid && !i_gcall.hw && gc_sel;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rx_push <= '0;
            o_gcall_exec <= '0;
        end
        else
        begin
            o_rx_push.valid <= i_gcall.valid && (i_gcall.hw || !gc_sel);
            o_rx_push.data <= i_gcall.code;
            o_gcall_exec.valid <= direct_call;
            o_gcall_exec.data <= i_gcall.code;
        end
    end

    // A new direct call wins over a software clear in the same cycle.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            status_code <= IGFD_CODE_RST;
            status_direct <= IGFD_BIT_RST;
        end
        else if (direct_call)
        begin
            status_code <= i_gcall.code;
            status_direct <= 1'h1;
        end
        else if (status_wr && i_wdata[IGFD_DIRECT_BIT])
        begin
            status_direct <= IGFD_BIT_RST;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb
    begin
        rd_ctrl = IGFD_RD_ZERO;
        rd_ctrl[IGFD_GCSEL_BIT] = gc_sel;
        rd_ctrl[IGFD_TXFL_BIT] = flush_busy[0];
        rd_ctrl[IGFD_RXFL_BIT] = flush_busy[1];
        rd_ctrl[IGFD_TXDMA_BIT] = tx_dma_en;
        rd_ctrl[IGFD_RXDMA_BIT] = rx_dma_en;
        rd_status = IGFD_RD_ZERO;
        rd_status[IGFD_CODE_W-1:0] = status_code;
        rd_status[IGFD_DIRECT_BIT] = status_direct;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= IGFD_RD_ZERO;
        end
        else if (i_re && i_addr == IGFD_CTRL_OFS)
        begin
            o_rdata <= rd_ctrl;
        end
        else if (i_re && i_addr == IGFD_STATUS_OFS)
        begin
            o_rdata <= rd_status;
        end
        else
        begin
            o_rdata <= IGFD_RD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence seq_tx_start;
        flush_start[0] && !flush_busy[0];
    endsequence

    sequence seq_rx_start;
        flush_start[1] && !flush_busy[1];
    endsequence

    sequence seq_tx_held;
        (o_tx_flush && $stable(gc_sel)) [*2];
    endsequence

    sequence seq_rx_held;
        (o_rx_flush && $stable(gc_sel)) [*2];
    endsequence

    chk_gcall_soft_fifo: assert property (
        (i_gcall.valid && !i_gcall.hw && !gc_sel) |=>
            (o_rx_push.valid && !o_gcall_exec.valid && o_rx_push.data == $past(i_gcall.code)))
        else $error("Transparent general call not pushed to receive FIFO.");

    chk_gcall_direct_exec: assert property (
        (i_gcall.valid && !i_gcall.hw && gc_sel) |=>
            (o_gcall_exec.valid && !o_rx_push.valid && status_direct
             && status_code == $past(i_gcall.code)))
        else $error("Direct general call not executed or code not stored.");

    chk_gcall_hw_transparent: assert property (
        (i_gcall.valid && i_gcall.hw) |=> (o_rx_push.valid && !o_gcall_exec.valid))
        else $error("Hardware general call not handled transparently.");

    chk_tx_flush_run: assert property (
        seq_tx_start |=> (o_tx_flush && gc_sel == $past(i_wdata[IGFD_GCSEL_BIT])) ##1 seq_tx_held)
        else $error("Transmit flush not held or configuration disturbed.");

    chk_tx_flush_done: assert property (
        seq_tx_start |=> o_tx_flush ##[1:40] !o_tx_flush)
        else $error("Transmit flush did not self-clear in time.");

    chk_rx_flush_done: assert property (
        seq_rx_start |=> o_rx_flush ##[1:40] !o_rx_flush)
        else $error("Receive flush did not self-clear in time.");

    chk_tx_dma_run: assert property (
        o_dma_tx_req |-> tx_dma_en)
        else $error("Transmit DMA request while interface idle.");

    chk_tx_dma_eot: assert property (
        i_dma_tx_eot |=> !tx_dma_en)
        else $error("Transmit DMA enable not cleared by end of transfer.");

    chk_rx_dma_eot: assert property (
        i_dma_rx_eot |=> (!rx_dma_en && !o_dma_rx_req))
        else $error("Receive DMA enable not cleared by end of transfer.");

    chk_tx_req_space: assert property (
        i_tx_fifo_full |-> !o_dma_tx_req)
        else $error("Transmit DMA request while FIFO full.");

    chk_rx_flush_run: assert property (
        seq_rx_start |=> (o_rx_flush && gc_sel == $past(i_wdata[IGFD_GCSEL_BIT])) ##1 seq_rx_held)
        else $error("Receive flush not held or configuration disturbed.");

    chk_tx_flush_mask: assert property (
        o_tx_flush |-> !o_dma_tx_req)
        else $error("Transmit DMA request while transmit side is flushing.");

    chk_rx_req_mask: assert property (
        (i_rx_fifo_empty || o_rx_flush) |-> !o_dma_rx_req)
        else $error("Receive DMA request while FIFO empty or flushing.");

    chk_tx_dma_issue: assert property (
        (tx_dma_en && !i_tx_fifo_full && !o_tx_flush) |-> o_dma_tx_req)
        else $error("Transmit DMA interface in run state issues no request.");

    chk_tx_dma_write: assert property (
        (ctrl_wr && !i_dma_tx_eot) |=> (tx_dma_en == $past(i_wdata[IGFD_TXDMA_BIT])))
        else $error("Transmit DMA enable does not follow the written value.");

    chk_rx_dma_write: assert property (
        (ctrl_wr && !i_dma_rx_eot) |=> (rx_dma_en == $past(i_wdata[IGFD_RXDMA_BIT])))
        else $error("Receive DMA enable does not follow the written value.");

    chk_status_sticky: assert property (
        (status_direct && !(status_wr && i_wdata[IGFD_DIRECT_BIT])) |=> status_direct)
        else $error("Direct general call status lost without a clear.");

endmodule : igfd_ctrl

// ---- testbench/igfd_dma_model.sv ----
// ------------------------------------------------------------
// DMA controller stand-in
// ------------------------------------------------------------
// Counts served requests and ends the transfer after LEN of them.
// In slow mode only every other cycle is served.
module igfd_dma_model
#(
    parameter int LEN = 4
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic i_slow,
    output logic o_eot
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    logic phase;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt <= 0;
            phase <= 1'b0;
            o_eot <= 1'b0;
        end
        else
        begin
            phase <= ~phase;
            o_eot <= 1'b0;
            if (i_req && (!i_slow || phase))
            begin
                cnt <= (cnt == LEN - 1) ? 0 : cnt + 1;
                o_eot <= (cnt == LEN - 1);
            end
        end
    end
endmodule : igfd_dma_model

// ---- testbench/tb.sv ----
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %s", $time, m); end end
module tb;
    import igfd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic sel;
        logic hw;
        logic [7:0] code;
        logic push;
    } igfd_row_t;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [IGFD_ADDR_W-1:0] i_addr = 8'h00;
    logic [IGFD_DATA_W-1:0] i_wdata = 32'h0000_0000;
    logic i_we = 1'b0;
    logic i_re = 1'b0;
    logic [IGFD_DATA_W-1:0] o_rdata;
    igfd_gcall_t i_gcall = '0;
    igfd_byte_t o_rx_push;
    igfd_byte_t o_gcall_exec;
    logic o_tx_flush, o_rx_flush, o_dma_tx_req, o_dma_rx_req, o_tx_dma_en, o_rx_dma_en;
    logic i_tx_fifo_full = 1'b1;
    logic i_rx_fifo_empty = 1'b1;
    logic i_dma_tx_eot, i_dma_rx_eot;
    logic slow = 1'b0;
    logic [IGFD_DATA_W-1:0] d;
    logic fl, en, rq;
    int n_fail = 0;
    int n_checks = 0;
    igfd_row_t rows [4] = '{'{1'b0, 1'b0, 8'h06, 1'b1}, '{1'b1, 1'b0, 8'h04, 1'b0},
                            '{1'b1, 1'b1, 8'h06, 1'b1}, '{1'b0, 1'b1, 8'h33, 1'b1}};
    always #50 i_clk = ~i_clk;
    igfd_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_gcall(i_gcall),
        .o_rx_push(o_rx_push), .o_gcall_exec(o_gcall_exec), .o_tx_flush(o_tx_flush),
        .o_rx_flush(o_rx_flush), .i_tx_fifo_full(i_tx_fifo_full),
        .i_rx_fifo_empty(i_rx_fifo_empty), .i_dma_tx_eot(i_dma_tx_eot),
        .i_dma_rx_eot(i_dma_rx_eot), .o_dma_tx_req(o_dma_tx_req),
        .o_dma_rx_req(o_dma_rx_req), .o_tx_dma_en(o_tx_dma_en), .o_rx_dma_en(o_rx_dma_en));
    igfd_dma_model dma_tx (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(o_dma_tx_req),
        .i_slow(slow), .o_eot(i_dma_tx_eot));
    igfd_dma_model dma_rx (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(o_dma_rx_req),
        .i_slow(slow), .o_eot(i_dma_rx_eot));
    // ------------------------------------------------------------
    // Register bus and verdict
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_we <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_we <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk);
        i_re <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1;
        v = o_rdata;
    endtask : rd
    task automatic print_verdict;
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial
    begin
        #3000000;
        n_fail++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(IGFD_CTRL_OFS, d);
        `CHK(d, IGFD_RD_ZERO, "control after reset")
        `CHK(o_tx_dma_en, 1'b0, "tx enable after reset")
        foreach (rows[i])
        begin
            wr(IGFD_CTRL_OFS, {25'h0, rows[i].sel, 6'h00});
            @(posedge i_clk);
            i_gcall <= '{valid: 1'b1, hw: rows[i].hw, code: rows[i].code};
            @(posedge i_clk);
            i_gcall <= '0;
            #1;
            `CHK(o_rx_push.valid, rows[i].push, "receive push")
            `CHK(o_gcall_exec.valid, ~rows[i].push, "direct execution")
            if (rows[i].push)
                `CHK(o_rx_push.data, rows[i].code, "pushed code")
            else
                `CHK(o_gcall_exec.data, rows[i].code, "executed code")
        end
        rd(IGFD_STATUS_OFS, d);
        `CHK(d[8:0], 9'h104, "status word")
        wr(IGFD_STATUS_OFS, 32'h0000_0100);
        rd(IGFD_STATUS_OFS, d);
        `CHK(d[8], 1'b0, "status clear")
        rd(8'h04, d);
        `CHK(d, IGFD_RD_ZERO, "unmapped read")
        for (int b = IGFD_TXFL_BIT; b <= IGFD_RXFL_BIT; b++)
        begin
            wr(IGFD_CTRL_OFS, (32'h1 << b) | 32'h0000_0040);
            fl = (b == IGFD_TXFL_BIT) ? o_tx_flush : o_rx_flush;
            `CHK(fl, 1'b1, "flush active")
            rd(IGFD_CTRL_OFS, d);
            `CHK(d[b], 1'b1, "flush bit busy")
            // Software only polls the control word while a flush runs.
            for (int k = 0; k < 30 && d[b] !== 1'b0; k++)
                rd(IGFD_CTRL_OFS, d);
            fl = (b == IGFD_TXFL_BIT) ? o_tx_flush : o_rx_flush;
            `CHK(d[b], 1'b0, "flush bit cleared")
            `CHK(d[6], 1'b1, "configuration kept")
            `CHK(fl, 1'b0, "flush released")
        end
        for (int b = IGFD_TXDMA_BIT; b <= IGFD_RXDMA_BIT; b++)
        begin
            // Only one DMA enable is ever set at a time.
            wr(IGFD_CTRL_OFS, 32'h1 << b);
            en = (b == IGFD_TXDMA_BIT) ? o_tx_dma_en : o_rx_dma_en;
            rq = (b == IGFD_TXDMA_BIT) ? o_dma_tx_req : o_dma_rx_req;
            `CHK(en, 1'b1, "dma enable set")
            `CHK(rq, 1'b0, "request masked")
            @(posedge i_clk);
            i_tx_fifo_full <= 1'b0;
            i_rx_fifo_empty <= 1'b0;
            slow <= (b == IGFD_RXDMA_BIT);
            for (int k = 0; k < 40 && en !== 1'b0; k++)
            begin
                @(posedge i_clk);
                #1;
                en = (b == IGFD_TXDMA_BIT) ? o_tx_dma_en : o_rx_dma_en;
            end
            rq = (b == IGFD_TXDMA_BIT) ? o_dma_tx_req : o_dma_rx_req;
            `CHK(en, 1'b0, "dma enable after end")
            `CHK(rq, 1'b0, "request after end")
            rd(IGFD_CTRL_OFS, d);
            `CHK(d[b], 1'b0, "enable bit cleared")
            @(posedge i_clk) i_tx_fifo_full <= 1'b1;
            i_rx_fifo_empty <= 1'b1;
        end
        wr(IGFD_CTRL_OFS, 32'h0000_0240);
        @(posedge i_clk) i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(IGFD_CTRL_OFS, d);
        `CHK(d, IGFD_RD_ZERO, "control after second reset")
        print_verdict();
    end
endmodule : tb
